/* core/network_config_regs.sv */
// network port configuration and status register bank
//
// Implementation choice: strobed register access.
`default_nettype none
module network_config_regs
    import netcfg_pkg::*;
#(
    parameter logic [47:0] MAC_RESET = 48'h0
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // power class pins and limit check triggers
    input wire logic [PWR_CLASS_W-1:0] i_power_class,
    input wire logic i_integ_time_wr,
    input wire logic i_frame_rate_wr,
    output logic [PWR_CLASS_W-1:0] o_power_limit,
    output logic o_limit_check,
    // active network configuration
    output logic o_dhcp_en,
    output logic o_stream_en,
    output logic o_ignore_checksum,
    output logic [47:0] o_mac_addr,
    output logic [31:0] o_ip_addr,
    output logic [31:0] o_subnet,
    output logic [31:0] o_gateway,
    output logic [15:0] o_ctrl_port,
    output logic [31:0] o_stream_ip,
    output logic [15:0] o_stream_port,
    output logic [31:0] o_v2d_ip,
    output logic [15:0] o_v2d_port,
    output logic [31:0] o_col_ip,
    output logic [15:0] o_col_port
);

    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction

    logic [CFG_W-1:0] cfg_q;
    logic [15:0] mac_hi_q, mac_mid_q, mac_lo_q;
    logic [15:0] ip_lo_q, ip_hi_q, snm_lo_q, snm_hi_q, gw_lo_q, gw_hi_q;
    logic [15:0] ctrl_port_q, st_ip_lo_q, st_ip_hi_q, st_port_q;
    logic [15:0] v2d_ip_lo_q, v2d_ip_hi_q, v2d_port_q;
    logic [15:0] col_ip_lo_q, col_ip_hi_q, col_port_q;
    logic [PWR_OVR_W-1:0] ovr_q;
    logic [PWR_CLASS_W-1:0] pwr_meta_q, pwr_sync_q;
    logic [DATA_W-1:0] rdata_d;
    logic limit_trig;

    logic wr_cfg, wr_mac_hi, wr_mac_mid, wr_mac_lo;
    logic wr_ip_lo, wr_ip_hi, wr_snm_lo, wr_snm_hi, wr_gw_lo, wr_gw_hi;
    logic wr_ctrl, wr_st_lo, wr_st_hi, wr_st_port, wr_ovr;
    logic wr_v2d_lo, wr_v2d_hi, wr_v2d_port, wr_col_lo, wr_col_hi, wr_col_port;

    // write decode
    assign wr_cfg = i_wr && addr_is(i_addr, ADDR_NET_CONFIG);
    assign wr_mac_hi = i_wr && addr_is(i_addr, ADDR_MAC_HIGH);
    assign wr_mac_mid = i_wr && addr_is(i_addr, ADDR_MAC_MID);
    assign wr_mac_lo = i_wr && addr_is(i_addr, ADDR_MAC_LOW);
    assign wr_ip_lo = i_wr && addr_is(i_addr, ADDR_IP_LOW);
    assign wr_ip_hi = i_wr && addr_is(i_addr, ADDR_IP_HIGH);
    assign wr_snm_lo = i_wr && addr_is(i_addr, ADDR_SUBNET_LOW);
    assign wr_snm_hi = i_wr && addr_is(i_addr, ADDR_SUBNET_HIGH);
    assign wr_gw_lo = i_wr && addr_is(i_addr, ADDR_GATEWAY_LOW);
    assign wr_gw_hi = i_wr && addr_is(i_addr, ADDR_GATEWAY_HIGH);
    assign wr_ctrl = i_wr && addr_is(i_addr, ADDR_CTRL_PORT);
    assign wr_st_lo = i_wr && addr_is(i_addr, ADDR_STREAM_IP_LOW);
    assign wr_st_hi = i_wr && addr_is(i_addr, ADDR_STREAM_IP_HIGH);
    assign wr_st_port = i_wr && addr_is(i_addr, ADDR_STREAM_PORT);
    assign wr_ovr = i_wr && addr_is(i_addr, ADDR_PWR_OVERRIDE);
    assign wr_v2d_lo = i_wr && addr_is(i_addr, ADDR_V2D_IP_LOW);
    assign wr_v2d_hi = i_wr && addr_is(i_addr, ADDR_V2D_IP_HIGH);
    assign wr_v2d_port = i_wr && addr_is(i_addr, ADDR_V2D_PORT);
    assign wr_col_lo = i_wr && addr_is(i_addr, ADDR_COL_IP_LOW);
    assign wr_col_hi = i_wr && addr_is(i_addr, ADDR_COL_IP_HIGH);
    assign wr_col_port = i_wr && addr_is(i_addr, ADDR_COL_PORT);
    assign limit_trig = i_integ_time_wr || i_frame_rate_wr;

    // feature enables
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cfg_q <= RST_NET_CONFIG;
            o_dhcp_en <= RST_NET_CONFIG[CFG_DHCP_BIT];
            o_stream_en <= RST_NET_CONFIG[CFG_STREAM_BIT];
            o_ignore_checksum <= RST_NET_CONFIG[CFG_NOCHK_BIT];
        end else if (wr_cfg) begin
            cfg_q <= i_wdata[CFG_W-1:0];
            o_dhcp_en <= i_wdata[CFG_DHCP_BIT];
            o_stream_en <= i_wdata[CFG_STREAM_BIT];
            o_ignore_checksum <= i_wdata[CFG_NOCHK_BIT];
        end
    end

    // mac staging and commit
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            mac_hi_q <= MAC_RESET[47:32];
            mac_mid_q <= MAC_RESET[31:16];
            mac_lo_q <= MAC_RESET[15:0];
            o_mac_addr <= MAC_RESET;
        end else begin
            if (wr_mac_hi) begin
                mac_hi_q <= i_wdata;
            end
            if (wr_mac_mid) begin
                mac_mid_q <= i_wdata;
            end
            if (wr_mac_lo) begin
                mac_lo_q <= i_wdata;
                o_mac_addr <= {mac_hi_q, mac_mid_q, i_wdata};
            end
        end
    end

    // ip, subnet and gateway staging and commit
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ip_lo_q <= RST_IP_LOW;
            ip_hi_q <= RST_IP_HIGH;
            snm_lo_q <= RST_SUBNET_LOW;
            snm_hi_q <= RST_SUBNET_HIGH;
            gw_lo_q <= RST_GATEWAY_LOW;
            gw_hi_q <= RST_GATEWAY_HIGH;
            o_ip_addr <= {RST_IP_HIGH, RST_IP_LOW};
            o_subnet <= {RST_SUBNET_HIGH, RST_SUBNET_LOW};
            o_gateway <= {RST_GATEWAY_HIGH, RST_GATEWAY_LOW};
        end else begin
            if (wr_ip_lo) begin
                ip_lo_q <= i_wdata;
            end
            if (wr_ip_hi) begin
                ip_hi_q <= i_wdata;
            end
            if (wr_snm_lo) begin
                snm_lo_q <= i_wdata;
            end
            if (wr_snm_hi) begin
                snm_hi_q <= i_wdata;
            end
            if (wr_gw_lo) begin
                gw_lo_q <= i_wdata;
            end
            if (wr_gw_hi) begin
                gw_hi_q <= i_wdata;
                o_ip_addr <= {ip_hi_q, ip_lo_q};
                o_subnet <= {snm_hi_q, snm_lo_q};
                o_gateway <= {i_wdata, gw_lo_q};
            end
        end
    end

    // control port and depth stream destination
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ctrl_port_q <= RST_CTRL_PORT;
            st_ip_lo_q <= RST_DEST_IP_LOW;
            st_ip_hi_q <= RST_DEST_IP_HIGH;
            st_port_q <= RST_STREAM_PORT;
            o_ctrl_port <= RST_CTRL_PORT;
            o_stream_ip <= {RST_DEST_IP_HIGH, RST_DEST_IP_LOW};
            o_stream_port <= RST_STREAM_PORT;
        end else begin
            if (wr_ctrl) begin
                ctrl_port_q <= i_wdata;
                o_ctrl_port <= i_wdata;
            end
            if (wr_st_lo) begin
                st_ip_lo_q <= i_wdata;
            end
            if (wr_st_hi) begin
                st_ip_hi_q <= i_wdata;
                o_stream_ip <= {i_wdata, st_ip_lo_q};
            end
            if (wr_st_port) begin
                st_port_q <= i_wdata;
                o_stream_port <= i_wdata;
            end
        end
    end

    // 2d video and colour stream destinations
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            v2d_ip_lo_q <= RST_DEST_IP_LOW;
            v2d_ip_hi_q <= RST_DEST_IP_HIGH;
            v2d_port_q <= RST_V2D_PORT;
            col_ip_lo_q <= RST_DEST_IP_LOW;
            col_ip_hi_q <= RST_DEST_IP_HIGH;
            col_port_q <= RST_COL_PORT;
            o_v2d_ip <= {RST_DEST_IP_HIGH, RST_DEST_IP_LOW};
            o_v2d_port <= RST_V2D_PORT;
            o_col_ip <= {RST_DEST_IP_HIGH, RST_DEST_IP_LOW};
            o_col_port <= RST_COL_PORT;
        end else begin
            if (wr_v2d_lo) begin
                v2d_ip_lo_q <= i_wdata;
            end
            if (wr_v2d_hi) begin
                v2d_ip_hi_q <= i_wdata;
                o_v2d_ip <= {i_wdata, v2d_ip_lo_q};
            end
            if (wr_v2d_port) begin
                v2d_port_q <= i_wdata;
                o_v2d_port <= i_wdata;
            end
            if (wr_col_lo) begin
                col_ip_lo_q <= i_wdata;
                o_col_ip[15:0] <= i_wdata;
            end
            if (wr_col_hi) begin
                col_ip_hi_q <= i_wdata;
                o_col_ip[31:16] <= i_wdata;
            end
            if (wr_col_port) begin
                col_port_q <= i_wdata;
                o_col_port <= i_wdata;
            end
        end
    end

    // power class pin synchroniser
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pwr_meta_q <= '0;
            pwr_sync_q <= '0;
        end else begin
            pwr_meta_q <= i_power_class;
            pwr_sync_q <= pwr_meta_q;
        end
    end

    // override register and limit evaluation
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ovr_q <= RST_PWR_OVERRIDE;
            o_power_limit <= RST_PWR_LIMIT;
            o_limit_check <= 1'b0;
        end else begin
            if (wr_ovr) begin
                ovr_q <= i_wdata[PWR_OVR_W-1:0];
            end
            o_limit_check <= limit_trig;
            if (limit_trig) begin
                if (ovr_q == PWR_OVR_NONE) begin
                    o_power_limit <= pwr_sync_q;
                end else begin
                    o_power_limit <= {1'b0, ovr_q};
                end
            end
        end
    end

    // read decode
    always_comb begin
        rdata_d = RD_UNMAPPED;
        if (addr_is(i_addr, ADDR_NET_CONFIG)) begin
            rdata_d = {{(DATA_W-CFG_W){1'b0}}, cfg_q};
        end else if (addr_is(i_addr, ADDR_MAC_HIGH)) begin
            rdata_d = mac_hi_q;
        end else if (addr_is(i_addr, ADDR_MAC_MID)) begin
            rdata_d = mac_mid_q;
        end else if (addr_is(i_addr, ADDR_MAC_LOW)) begin
            rdata_d = mac_lo_q;
        end else if (addr_is(i_addr, ADDR_IP_LOW)) begin
            rdata_d = ip_lo_q;
        end else if (addr_is(i_addr, ADDR_IP_HIGH)) begin
            rdata_d = ip_hi_q;
        end else if (addr_is(i_addr, ADDR_SUBNET_LOW)) begin
            rdata_d = snm_lo_q;
        end else if (addr_is(i_addr, ADDR_SUBNET_HIGH)) begin
            rdata_d = snm_hi_q;
        end else if (addr_is(i_addr, ADDR_GATEWAY_LOW)) begin
            rdata_d = gw_lo_q;
        end else if (addr_is(i_addr, ADDR_GATEWAY_HIGH)) begin
            rdata_d = gw_hi_q;
        end else if (addr_is(i_addr, ADDR_CTRL_PORT)) begin
            rdata_d = ctrl_port_q;
        end else if (addr_is(i_addr, ADDR_STREAM_IP_LOW)) begin
            rdata_d = st_ip_lo_q;
        end else if (addr_is(i_addr, ADDR_STREAM_IP_HIGH)) begin
            rdata_d = st_ip_hi_q;
        end else if (addr_is(i_addr, ADDR_STREAM_PORT)) begin
            rdata_d = st_port_q;
        end else if (addr_is(i_addr, ADDR_PWR_STATUS)) begin
            rdata_d = {{(DATA_W-PWR_CLASS_W){1'b0}}, pwr_sync_q};
        end else if (addr_is(i_addr, ADDR_PWR_OVERRIDE)) begin
            rdata_d = {{(DATA_W-PWR_OVR_W){1'b0}}, ovr_q};
        end else if (addr_is(i_addr, ADDR_V2D_IP_LOW)) begin
            rdata_d = v2d_ip_lo_q;
        end else if (addr_is(i_addr, ADDR_V2D_IP_HIGH)) begin
            rdata_d = v2d_ip_hi_q;
        end else if (addr_is(i_addr, ADDR_V2D_PORT)) begin
            rdata_d = v2d_port_q;
        end else if (addr_is(i_addr, ADDR_COL_IP_LOW)) begin
            rdata_d = col_ip_lo_q;
        end else if (addr_is(i_addr, ADDR_COL_IP_HIGH)) begin
            rdata_d = col_ip_hi_q;
        end else if (addr_is(i_addr, ADDR_COL_PORT)) begin
            rdata_d = col_port_q;
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= RD_UNMAPPED;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= RD_UNMAPPED;
        end
    end

    // checks
    a_cfg_dhcp_bit: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_cfg |=> o_dhcp_en == $past(i_wdata[CFG_DHCP_BIT]))
        else $error("dhcp enable does not follow config write");

    a_cfg_stream_bits: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_cfg |=> o_stream_en == $past(i_wdata[CFG_STREAM_BIT])
            && o_ignore_checksum == $past(i_wdata[CFG_NOCHK_BIT]))
        else $error("stream enables do not follow config write");

    a_mac_stage_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
        (wr_mac_hi || wr_mac_mid) |=> $stable(o_mac_addr))
        else $error("upper mac write changed active mac");

    a_mac_commit_all: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_mac_hi ##1 (wr_mac_lo && !wr_mac_hi)
            |=> o_mac_addr[47:32] == $past(i_wdata, 2)
            && o_mac_addr[15:0] == $past(i_wdata))
        else $error("mac commit lost staged or written word");

    a_net_stage_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
        (wr_ip_lo || wr_ip_hi || wr_snm_lo || wr_snm_hi || wr_gw_lo)
            |=> $stable(o_ip_addr) && $stable(o_subnet) && $stable(o_gateway))
        else $error("staged network word changed active config");

    a_net_commit_set: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_gw_hi |=> o_ip_addr == {ip_hi_q, ip_lo_q}
            && o_subnet == {snm_hi_q, snm_lo_q}
            && o_gateway == {gw_hi_q, gw_lo_q})
        else $error("gateway commit did not copy staged set");

    a_stream_commit: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_st_lo ##1 wr_st_hi |=> o_stream_ip == {$past(i_wdata), $past(i_wdata, 2)})
        else $error("stream address commit wrong");

    a_v2d_commit: assert property (@(posedge i_mclk) disable iff (i_reset)
        (wr_v2d_lo |=> $stable(o_v2d_ip))
        and (wr_v2d_hi |=> o_v2d_ip[31:16] == $past(i_wdata)))
        else $error("2d stream address staging wrong");

    a_override_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
        (wr_ovr && !limit_trig) |=> $stable(o_power_limit) && !o_limit_check)
        else $error("override write acted on power limit");

    a_limit_select: assert property (@(posedge i_mclk) disable iff (i_reset)
        (limit_trig && ovr_q != PWR_OVR_NONE) |=> o_power_limit == {1'b0, $past(ovr_q)})
        else $error("override class not applied on limit check");

    a_status_ro_write: assert property (@(posedge i_mclk) disable iff (i_reset)
        (i_wr && addr_is(i_addr, ADDR_PWR_STATUS))
            |=> $stable(ovr_q) && $stable(cfg_q) && $stable(o_mac_addr))
        else $error("status write disturbed other registers");

    a_rdata_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
        !i_rd |=> o_rdata == RD_UNMAPPED)
        else $error("read data outside read slot");

endmodule
`default_nettype wire

/* core/netcfg_pkg.sv */
// constants for the network configuration register bank
`default_nettype none
package netcfg_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    // register offsets
    localparam logic [15:0] ADDR_NET_CONFIG = 16'h0240;
    localparam logic [15:0] ADDR_MAC_HIGH = 16'h0241;
    localparam logic [15:0] ADDR_MAC_MID = 16'h0242;
    localparam logic [15:0] ADDR_MAC_LOW = 16'h0243;
    localparam logic [15:0] ADDR_IP_LOW = 16'h0244;
    localparam logic [15:0] ADDR_IP_HIGH = 16'h0245;
    localparam logic [15:0] ADDR_SUBNET_LOW = 16'h0246;
    localparam logic [15:0] ADDR_SUBNET_HIGH = 16'h0247;
    localparam logic [15:0] ADDR_GATEWAY_LOW = 16'h0248;
    localparam logic [15:0] ADDR_GATEWAY_HIGH = 16'h0249;
    localparam logic [15:0] ADDR_CTRL_PORT = 16'h024b;
    localparam logic [15:0] ADDR_STREAM_IP_LOW = 16'h024c;
    localparam logic [15:0] ADDR_STREAM_IP_HIGH = 16'h024d;
    localparam logic [15:0] ADDR_STREAM_PORT = 16'h024e;
    localparam logic [15:0] ADDR_PWR_STATUS = 16'h0250;
    localparam logic [15:0] ADDR_PWR_OVERRIDE = 16'h0251;
    localparam logic [15:0] ADDR_V2D_IP_LOW = 16'h0252;
    localparam logic [15:0] ADDR_V2D_IP_HIGH = 16'h0253;
    localparam logic [15:0] ADDR_V2D_PORT = 16'h0254;
    localparam logic [15:0] ADDR_COL_IP_LOW = 16'h0256;
    localparam logic [15:0] ADDR_COL_IP_HIGH = 16'h0257;
    localparam logic [15:0] ADDR_COL_PORT = 16'h0258;
    // network_config fields and power field widths
    localparam int CFG_DHCP_BIT = 0;
    localparam int CFG_STREAM_BIT = 1;
    localparam int CFG_NOCHK_BIT = 2;
    localparam int CFG_W = 3;
    localparam int PWR_CLASS_W = 3;
    localparam int PWR_OVR_W = 2;
    // reset values
    localparam logic [2:0] RST_NET_CONFIG = 3'h6;
    localparam logic [15:0] RST_IP_LOW = 16'h000a;
    localparam logic [15:0] RST_IP_HIGH = 16'hc0a8;
    localparam logic [15:0] RST_SUBNET_LOW = 16'hff00;
    localparam logic [15:0] RST_SUBNET_HIGH = 16'hffff;
    localparam logic [15:0] RST_GATEWAY_LOW = 16'h0001;
    localparam logic [15:0] RST_GATEWAY_HIGH = 16'hc0a8;
    localparam logic [15:0] RST_CTRL_PORT = 16'h2711;
    localparam logic [15:0] RST_DEST_IP_LOW = 16'h0001;
    localparam logic [15:0] RST_DEST_IP_HIGH = 16'he000;
    localparam logic [15:0] RST_STREAM_PORT = 16'h2712;
    localparam logic [15:0] RST_V2D_PORT = 16'h2714;
    localparam logic [15:0] RST_COL_PORT = 16'h2716;
    localparam logic [1:0] RST_PWR_OVERRIDE = 2'h0;
    localparam logic [2:0] RST_PWR_LIMIT = 3'h0;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;
    // power class codes
    localparam logic [2:0] PWR_CLASS_13W = 3'h1;
    localparam logic [2:0] PWR_CLASS_MID = 3'h2;
    localparam logic [2:0] PWR_CLASS_UNLIMITED = 3'h3;
    localparam logic [2:0] PWR_CLASS_AUX_SUPPLY = 3'h7;
    localparam logic [1:0] PWR_OVR_NONE = 2'h0;
endpackage
`default_nettype wire

/* tb/network_config_regs_bench.sv */
// self-checking bench for the network configuration register bank
`default_nettype none
module network_config_regs_bench
    import netcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and register port
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    // power class side
    logic [2:0] i_power_class = 3'h7;
    logic i_integ_time_wr = 1'b0;
    logic i_frame_rate_wr = 1'b0;
    logic [2:0] o_power_limit;
    logic o_limit_check;
    // active configuration
    logic o_dhcp_en, o_stream_en, o_ignore_checksum;
    logic [47:0] o_mac_addr;
    logic [31:0] o_ip_addr, o_subnet, o_gateway, o_stream_ip, o_v2d_ip, o_col_ip;
    logic [15:0] o_ctrl_port, o_stream_port, o_v2d_port, o_col_port;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h90c1;
    logic [15:0] v [6];
    logic [2:0] pc [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    logic [15:0] ra [18] = '{16'h0240, 16'h0244, 16'h0245, 16'h0246, 16'h0247, 16'h0248,
        16'h0249, 16'h024b, 16'h024c, 16'h024d, 16'h024e, 16'h0251, 16'h0252, 16'h0253,
        16'h0254, 16'h0256, 16'h0257, 16'h0258};
    logic [15:0] rv [18] = '{16'h0006, 16'h000a, 16'hc0a8, 16'hff00, 16'hffff, 16'h0001,
        16'hc0a8, 16'h2711, 16'h0001, 16'he000, 16'h2712, 16'h0000, 16'h0001, 16'he000,
        16'h2714, 16'h0001, 16'he000, 16'h2716};

    network_config_regs network_config_regs_inst (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_power_class(i_power_class), .i_integ_time_wr(i_integ_time_wr),
        .i_frame_rate_wr(i_frame_rate_wr), .o_power_limit(o_power_limit),
        .o_limit_check(o_limit_check), .o_dhcp_en(o_dhcp_en), .o_stream_en(o_stream_en),
        .o_ignore_checksum(o_ignore_checksum), .o_mac_addr(o_mac_addr),
        .o_ip_addr(o_ip_addr), .o_subnet(o_subnet), .o_gateway(o_gateway),
        .o_ctrl_port(o_ctrl_port), .o_stream_ip(o_stream_ip),
        .o_stream_port(o_stream_port), .o_v2d_ip(o_v2d_ip), .o_v2d_port(o_v2d_port),
        .o_col_ip(o_col_ip), .o_col_port(o_col_port));

    always #2 i_mclk = ~i_mclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function logic [15:0] rnd();
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
        end
        return seed[15:0];
    endfunction

    function automatic logic [2:0] exp_limit(input logic [1:0] ovr, input logic [2:0] cls);
        return (ovr == 2'h0) ? cls : {1'b0, ovr};
    endfunction

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t readback %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t output %h expected %h", $time, got, exp);
        end
    endtask

    // strobe raised here, taken at the next edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b0;
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
    endtask

    task automatic idle();
        @(posedge i_mclk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        i_integ_time_wr <= 1'b0;
        i_frame_rate_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge i_mclk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk_reg(o_rdata, exp);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        logic [2:0] lim;
        lim = RST_PWR_LIMIT;
        repeat (4) @(posedge i_mclk);
        i_reset <= 1'b0;
        #1;
        chk_out({o_ignore_checksum, o_stream_en, o_dhcp_en}, 3'b110);
        chk_out({o_ip_addr, o_ctrl_port}, 48'hc0a8000a_2711);
        for (int i = 0; i < 18; i++) begin
            rd(ra[i], rv[i]);
        end
        rd(16'h0250, 16'h0007);
        for (int i = 0; i < 8; i++) begin
            v[0] = rnd();
            wr(16'h0240, {v[0][15:3], i[2:0]});
            idle();
            chk_out({o_ignore_checksum, o_stream_en, o_dhcp_en}, i[2:0]);
            rd(16'h0240, {13'h0000, i[2:0]});
        end
        for (int i = 0; i < 6; i++) begin
            v[i] = rnd();
        end
        wr(16'h0241, v[0]);
        wr(16'h0242, v[1]);
        idle();
        chk_out(o_mac_addr, 48'h0);
        rd(16'h0241, v[0]);
        rd(16'h0242, v[1]);
        wr(16'h0243, v[2]);
        idle();
        chk_out(o_mac_addr, {v[0], v[1], v[2]});
        wr(16'h0241, v[3]);
        wr(16'h0243, v[4]);
        idle();
        chk_out(o_mac_addr, {v[3], v[1], v[4]});
        for (int i = 0; i < 5; i++) begin
            wr(16'h0244 + 16'(i), v[i]);
        end
        idle();
        chk_out({o_ip_addr, o_gateway[15:0]}, 48'hc0a8000a_0001);
        chk_out(o_subnet, 32'hffffff00);
        rd(16'h0247, v[3]);
        wr(16'h0249, v[5]);
        idle();
        chk_out({o_ip_addr, o_subnet[15:0]}, {v[1], v[0], v[2]});
        chk_out({o_subnet[31:16], o_gateway}, {v[3], v[5], v[4]});
        for (int k = 0; k < 2; k++) begin
            wr(k ? 16'h0252 : 16'h024c, v[2 * k]);
            idle();
            chk_out(k ? o_v2d_ip : o_stream_ip, 32'he0000001);
            wr(k ? 16'h0253 : 16'h024d, v[2 * k + 1]);
            idle();
            chk_out(k ? o_v2d_ip : o_stream_ip, {v[2 * k + 1], v[2 * k]});
        end
        wr(16'h024c, v[4]);
        wr(16'h024d, v[5]);
        idle();
        chk_out(o_stream_ip, {v[5], v[4]});
        wr(16'h0256, v[4]);
        idle();
        chk_out(o_col_ip, {16'he000, v[4]});
        wr(16'h0257, v[5]);
        wr(16'h024b, v[0]);
        wr(16'h024e, v[1]);
        wr(16'h0254, v[2]);
        wr(16'h0258, v[3]);
        idle();
        chk_out({o_col_ip, o_col_port}, {v[5], v[4], v[3]});
        chk_out({o_ctrl_port, o_stream_port, o_v2d_port}, {v[0], v[1], v[2]});
        for (int k = 0; k < 4; k++) begin
            @(posedge i_mclk);
            i_power_class <= pc[k];
            wr(16'h0250, rnd());
            repeat (3) idle();
            rd(16'h0250, {13'h0000, pc[k]});
        end
        rd(16'h0251, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            v[0] = rnd();
            wr(16'h0251, {v[0][15:2], k[1:0]});
            repeat (2) idle();
            chk_out({o_limit_check, o_power_limit}, {1'b0, lim});
            rd(16'h0251, {14'h0000, k[1:0]});
            @(posedge i_mclk);
            if (k[0]) begin
                i_integ_time_wr <= 1'b1;
            end else begin
                i_frame_rate_wr <= 1'b1;
            end
            idle();
            lim = exp_limit(k[1:0], 3'h7);
            chk_out({o_limit_check, o_power_limit}, {1'b1, lim});
            idle();
            chk_out(o_limit_check, 1'b0);
        end
        wr(16'h024a, rnd());
        rd(16'h024a, RD_UNMAPPED);
        rd(16'h0240, 16'h0007);
        end_of_test();
    end
endmodule
`default_nettype wire
